/* verilog/ppc_process_pi_controller.sv */
// Process PI controller with AHB-Lite register slave
`timescale 1ns/1ps

module ppc_process_pi_controller
	import ppc_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES,
	parameter int unsigned NSETS    = SET_CNT
)(
	input  wire logic                 sys_clk,       // System clock, 50 MHz
	input  wire logic                 sys_rst,       // Synchronous reset, active high
	input  wire logic                 hsel,          // AHB slave select
	input  wire logic [31:0]          haddr,         // AHB address
	input  wire logic [1:0]           htrans,        // AHB transfer type
	input  wire logic                 hwrite,        // AHB write
	input  wire logic [2:0]           hsize,         // AHB size
	input  wire logic [31:0]          hwdata,        // AHB write data
	input  wire logic                 hready,        // AHB bus ready
	output logic      [31:0]          hrdata,        // AHB read data
	output logic                      hreadyout,     // AHB slave ready
	output logic                      hresp,         // AHB response, always OKAY
	input  wire logic signed [PW-1:0] refPct,        // Reference percentage
	input  wire logic signed [PW-1:0] multifunction_analog_input_one, // Actual, analog
	input  wire logic signed [PW-1:0] repetition_frequency_input,     // Actual, frequency
	input  wire logic                 run_enable_input, // Controller release pin
	input  wire logic [1:0]           dataSetSel,    // Data set select pins
	output logic signed [FW-1:0]      freqDemand,    // Output frequency demand
	output ppc_status_t               ctlStatus      // Controller status flags
);

	localparam int TCW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

	// Elaboration checks
	if (TICK_CYC < 2) $error("TICK_CYC must be at least 2");
	if (NSETS < 1 || NSETS > SET_CNT) $error("NSETS out of range");

	typedef struct packed {
		logic                 hrdyo;
		logic [31:0]          rdata;
		logic                 wrPend;
		logic [11:0]          wrAddr;
		logic [11:0]          cfg;
		ppc_mode_t            mode;
		logic [7:0]           src;
		logic signed [FW-1:0] fMin;
		logic signed [FW-1:0] fMax;
		logic [FW-1:0]        decel;
		ppc_set_t [NSETS-1:0] sets;
		logic                 runS1;
		logic                 runS2;
		logic [1:0]           dsS1;
		logic [1:0]           dsS2;
		logic [TCW-1:0]       tickCnt;
		ppc_ctl_t             ctl;
		logic signed [FW-1:0] fOut;
		logic signed [FW-1:0] integ;
		logic signed [PW:0]   dev;
		ppc_status_t          stat;
	} ppc_state_t;

	ppc_state_t state_r;
	ppc_state_t state_nxt;

	// Integer square root of a 16-bit value
	function automatic logic [7:0] isqrt(input logic [15:0] x);
		logic [7:0] r;
		logic [7:0] c;
		r = 8'h00;
		c = 8'h00;
		for (int b = 7; b >= 0; b--)
		begin
			c = r | 8'(8'h01 << b);
			if (16'(c) * 16'(c) <= x)
				r = c;
		end
		return r;
	endfunction : isqrt

	logic                 tick;
	logic                 busAcc;
	logic [11:0]          rdAddr;
	logic [31:0]          rdVal;
	logic [1:0]           setIdx;
	ppc_set_t             cur;
	logic                 cfgOk;
	logic                 monMode;
	logic signed [PW-1:0] actRaw;
	logic signed [PW-1:0] actUse;
	logic                 missNow;
	logic signed [PW:0]   devNow;
	logic [PW:0]          absDev;
	logic signed [47:0]   prod;
	logic signed [47:0]   pRaw;
	logic signed [47:0]   pCl;
	logic signed [47:0]   iStep;
	logic signed [47:0]   iSum;
	logic signed [47:0]   piSum;
	logic signed [47:0]   lo;
	logic signed [47:0]   hi;
	logic signed [FW-1:0] piOut;
	logic signed [FW-1:0] fbTgt;
	logic signed [FW-1:0] rampOut;
	logic signed [FW-1:0] refScaled;
	logic signed [FW-1:0] fixFloor;
	logic                 holdNext;
	logic                 fallNow;

	// Tick strobe and active data set
	always_comb
	begin
		tick   = (state_r.tickCnt == TCW'(TICK_CYC - 1));
		busAcc = hsel && htrans[1] && hready;
		setIdx = (32'(state_r.dsS2) < NSETS) ? state_r.dsS2 : 2'h0;
		cur    = state_r.sets[setIdx];
	end

	// Actual value path, deviation and PI terms, evaluated every cycle
	always_comb
	begin
		cfgOk   = (state_r.cfg == CFG_A) || (state_r.cfg == CFG_B) || (state_r.cfg == CFG_C);
		monMode = (state_r.mode == MODE_STD) || (state_r.mode == MODE_FILL1) || (state_r.mode == MODE_FILL2);
		if (state_r.src == SRC_ANALOG1)
			actRaw = multifunction_analog_input_one;
		else if (state_r.src == SRC_REPFREQ)
			actRaw = repetition_frequency_input;
		else
			actRaw = '0;
		missNow = (actRaw < MISS_THR);
		// Square root keeps 0.01 % scaling: sqrt(x/10000)*10000 = sqrt(x)*100
		if (state_r.mode == MODE_VOLFLOW)
			actUse = (actRaw < 0) ? '0 : PW'(16'(isqrt(actRaw)) * 16'h0064);
		else
			actUse = actRaw;
		devNow = (PW+1)'(refPct) - (PW+1)'(actUse);
		absDev = devNow[PW] ? (PW+1)'(-devNow) : (PW+1)'(devNow);
		// Sign of gain sets direction of control
		prod   = 48'(cur.gain) * 48'(devNow);
		pRaw   = prod / 48'sd100;
		if (pRaw > 48'($signed({1'b0, cur.maxP})))
			pCl = 48'($signed({1'b0, cur.maxP}));
		else if (pRaw < -48'($signed({1'b0, cur.maxP})))
			pCl = -48'($signed({1'b0, cur.maxP}));
		else
			pCl = pRaw;
		// Zero integral time switches the integral part off
		if (cur.ti == 16'h0000 || absDev <= (PW+1)'(cur.hyst))
			iStep = '0;
		else
			iStep = prod / (48'($signed({1'b0, cur.ti})) * 48'sd100);
		iSum = 48'(state_r.integ) + iStep;
		if (iSum > 48'(state_r.fMax))
			iSum = 48'(state_r.fMax);
		else if (iSum < -48'(state_r.fMax))
			iSum = -48'(state_r.fMax);
		piSum = iSum + pCl;
		hi    = 48'(state_r.fMax);
		lo    = (state_r.mode == MODE_SPEED) ? -48'(state_r.fMax) : 48'(state_r.fMin);
		if (piSum > hi)
			piOut = FW'(hi);
		else if (piSum < lo)
			piOut = FW'(lo);
		else
			piOut = FW'(piSum);
		refScaled = FW'((48'(refPct) * 48'(state_r.fMax)) / 48'(PCT_FULL));
	end

	// Fallback targets and ramp at deceleration rate
	always_comb
	begin
		fixFloor = (cur.fixF < state_r.fMin) ? state_r.fMin : cur.fixF;
		// Fill level 2 hold: returning actual or large deviation releases it
		if (state_r.mode != MODE_FILL2 || missNow)
			holdNext = 1'b0;
		else if (state_r.stat.missing)
			holdNext = 1'b0;
		else if (devNow > $signed((PW+1)'(cur.hyst)))
			holdNext = 1'b0;
		else if (devNow <= 0)
			holdNext = 1'b1;
		else
			holdNext = state_r.stat.fl2Hold;
		fallNow = (monMode && missNow) || holdNext;
		if (holdNext)
			fbTgt = state_r.fMin;
		else if (state_r.mode == MODE_STD)
			fbTgt = state_r.fMin;
		else
			fbTgt = fixFloor;
		// Same step both ways, so a fallback above the present value is reached too
		if (fbTgt - state_r.fOut > $signed({1'b0, state_r.decel}))
			rampOut = state_r.fOut + FW'(state_r.decel);
		else if (state_r.fOut - fbTgt > $signed({1'b0, state_r.decel}))
			rampOut = state_r.fOut - FW'(state_r.decel);
		else
			rampOut = fbTgt;
	end

	// Register read multiplexer
	always_comb
	begin
		rdAddr = haddr[11:0];
		rdVal  = 32'h00000000;
		if (rdAddr[11:7] == SET_REGION)
		begin
			if (32'(rdAddr[6:5]) < NSETS)
			begin
				case (rdAddr[4:0])
					SOFS_FIXF: rdVal = 32'(state_r.sets[rdAddr[6:5]].fixF);
					SOFS_MAXP: rdVal = 32'(state_r.sets[rdAddr[6:5]].maxP);
					SOFS_HYST: rdVal = 32'(state_r.sets[rdAddr[6:5]].hyst);
					SOFS_GAIN: rdVal = 32'(state_r.sets[rdAddr[6:5]].gain);
					SOFS_TI:   rdVal = 32'(state_r.sets[rdAddr[6:5]].ti);
					default:   rdVal = 32'h00000000;
				endcase
			end
		end
		else
		begin
			case (rdAddr)
				OFS_CONFIG:  rdVal = 32'(state_r.cfg);
				OFS_MODE:    rdVal = 32'(state_r.mode);
				OFS_SOURCE:  rdVal = 32'(state_r.src);
				OFS_STARTFN: rdVal = 32'(START_FN_CODE);
				OFS_FMIN:    rdVal = 32'(state_r.fMin);
				OFS_FMAX:    rdVal = 32'(state_r.fMax);
				OFS_DECEL:   rdVal = 32'(state_r.decel);
				OFS_STATUS:  rdVal = {22'h000000, setIdx, 1'b0, state_r.stat, state_r.ctl};
				OFS_FOUT:    rdVal = 32'(state_r.fOut);
				OFS_DEV:     rdVal = 32'(state_r.dev);
				default:     rdVal = 32'h00000000;
			endcase
		end
	end

	// Next state: bus slave, synchronisers, tick and controller
	always_comb
	begin
		state_nxt        = state_r;
		state_nxt.hrdyo  = 1'b1;
		state_nxt.wrPend = busAcc && hwrite && (hsize == 3'h2);
		state_nxt.wrAddr = haddr[11:0];
		state_nxt.rdata  = (busAcc && !hwrite) ? rdVal : 32'h00000000;
		// Write data arrives one cycle after the address phase
		if (state_r.wrPend)
		begin
			if (state_r.wrAddr[11:7] == SET_REGION)
			begin
				if (32'(state_r.wrAddr[6:5]) < NSETS)
				begin
					case (state_r.wrAddr[4:0])
						SOFS_FIXF: state_nxt.sets[state_r.wrAddr[6:5]].fixF = hwdata[FW-1:0];
						SOFS_MAXP: state_nxt.sets[state_r.wrAddr[6:5]].maxP = hwdata[FW-1:0];
						SOFS_HYST: state_nxt.sets[state_r.wrAddr[6:5]].hyst = hwdata[PW-1:0];
						SOFS_GAIN: state_nxt.sets[state_r.wrAddr[6:5]].gain = hwdata[PW-1:0];
						SOFS_TI:   state_nxt.sets[state_r.wrAddr[6:5]].ti = hwdata[15:0];
						default:   ;
					endcase
				end
			end
			else
			begin
				case (state_r.wrAddr)
					OFS_CONFIG: state_nxt.cfg = hwdata[11:0];
					OFS_MODE:   if (hwdata[2:0] <= 3'h5) state_nxt.mode = ppc_mode_t'(hwdata[2:0]);
					OFS_SOURCE: state_nxt.src = hwdata[7:0];
					OFS_FMIN:   state_nxt.fMin = hwdata[FW-1:0];
					OFS_FMAX:   state_nxt.fMax = hwdata[FW-1:0];
					OFS_DECEL:  state_nxt.decel = hwdata[FW-1:0];
					default:    ;
				endcase
			end
		end
		// Pins come from outside the clock domain
		state_nxt.runS1   = run_enable_input;
		state_nxt.runS2   = state_r.runS1;
		state_nxt.dsS1    = dataSetSel;
		state_nxt.dsS2    = state_r.dsS1;
		state_nxt.tickCnt = tick ? '0 : state_r.tickCnt + TCW'(1);
		state_nxt.stat.absent = !cfgOk;
		// Off and release loss act at once; the loop itself moves on the tick
		if (!cfgOk || state_r.mode == MODE_OFF)
		begin
			state_nxt.ctl   = CTL_BYPASS;
			state_nxt.integ = '0;
			state_nxt.stat.active   = 1'b0;
			state_nxt.stat.fallback = 1'b0;
			state_nxt.stat.fl2Hold  = 1'b0;
			if (tick)
				state_nxt.fOut = refScaled;
		end
		else if (!state_r.runS2)
		begin
			state_nxt.ctl   = CTL_IDLE;
			state_nxt.integ = '0;
			state_nxt.fOut  = '0;
			state_nxt.stat.active   = 1'b0;
			state_nxt.stat.fallback = 1'b0;
			state_nxt.stat.fl2Hold  = 1'b0;
		end
		else if (tick)
		begin
			state_nxt.stat.active   = 1'b1;
			state_nxt.stat.missing  = missNow;
			state_nxt.stat.fl2Hold  = holdNext;
			state_nxt.stat.fallback = fallNow;
			state_nxt.dev           = devNow;
			unique case (state_r.ctl)
				CTL_IDLE, CTL_BYPASS, CTL_RUN, CTL_FALL:
				begin
					if (fallNow)
					begin
						state_nxt.ctl  = CTL_FALL;
						state_nxt.fOut = rampOut;
					end
					else
					begin
						state_nxt.ctl   = CTL_RUN;
						state_nxt.fOut  = piOut;
						state_nxt.integ = FW'(iSum);
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_r       <= '0;
			state_r.cfg   <= RST_CONFIG;
			state_r.mode  <= MODE_OFF;
			state_r.src   <= RST_SOURCE;
			state_r.fMin  <= RST_FMIN;
			state_r.fMax  <= RST_FMAX;
			state_r.decel <= RST_DECEL;
			state_r.ctl   <= CTL_BYPASS;
			state_r.hrdyo <= 1'b1;
			for (int i = 0; i < NSETS; i++)
				state_r.sets[i] <= '{fixF: RST_FIXF, maxP: RST_MAXP, hyst: RST_HYST, gain: RST_GAIN, ti: RST_TI};
		end
		else
			state_r <= state_nxt;
	end
	// Outputs straight from the state register, hresp tied to OKAY
	assign hrdata     = state_r.rdata;
	assign hreadyout  = state_r.hrdyo;
	assign hresp      = 1'b0;
	assign freqDemand = state_r.fOut;
	assign ctlStatus  = state_r.stat;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_absent_bypass:  assert property (tick && !cfgOk |=> state_r.ctl == CTL_BYPASS && freqDemand == $past(refScaled))
		else $error("absent controller did not pass the reference");
	a_run_gate:       assert property (cfgOk && state_r.mode != MODE_OFF && !state_r.runS2 |=> !ctlStatus.active && freqDemand == 0)
		else $error("controller ran without release");
	a_int_clear_off:  assert property (state_r.mode == MODE_OFF |=> state_r.integ == 0)
		else $error("integrator not cleared in mode 0");
	a_p_clamp:        assert property (pCl <= 48'($signed({1'b0, cur.maxP})) && pCl >= -48'($signed({1'b0, cur.maxP})))
		else $error("proportional term beyond its limit");
	a_miss_flag:      assert property (tick && cfgOk && state_r.mode != MODE_OFF && state_r.runS2
		|=> ctlStatus.missing == $past(missNow))
		else $error("missing flag does not track threshold");
	a_ramp_step:      assert property (tick && state_r.runS2 && cfgOk && state_r.mode != MODE_OFF && fallNow
		|=> (freqDemand - $past(state_r.fOut) <= $signed({1'b0, $past(state_r.decel)}))
		&& ($past(state_r.fOut) - freqDemand <= $signed({1'b0, $past(state_r.decel)})))
		else $error("fallback ramp step exceeds deceleration");
	a_fix_floor:      assert property (state_r.mode == MODE_FILL1 |-> fixFloor >= state_r.fMin)
		else $error("fallback target under minimum frequency");
	a_fill2_hold:     assert property (tick && state_r.runS2 && cfgOk && state_r.mode == MODE_FILL2 && !missNow
		&& !state_r.stat.missing && devNow <= 0 |=> ctlStatus.fl2Hold && state_r.ctl == CTL_FALL)
		else $error("fill level 2 did not hold on non-positive deviation");
	a_run_bounds:     assert property (tick && state_r.runS2 && cfgOk && !fallNow
		&& state_r.mode != MODE_OFF && state_r.mode != MODE_SPEED
		|=> freqDemand <= $past(state_r.fMax) && freqDemand >= $past(state_r.fMin))
		else $error("closed loop output outside frequency limits");
	a_tick_spacing:   assert property (tick |=> !tick [*1] ##0 state_r.tickCnt == TCW'(0))
		else $error("tick spacing wrong");
endmodule : ppc_process_pi_controller

/* include/ppc_pkg.sv */
// Shared constants, register map and carrier types of the process PI controller
package ppc_pkg;
	// Clock and control tick timing
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned CTRL_TICK_NS   = 1000000;
	localparam int unsigned TICK_CYCLES    = CTRL_TICK_NS / CLK_PERIOD_NS;
	// Value widths: percent in 0.01 %, frequency in 0.01 Hz
	localparam int          PW             = 16;
	localparam int          FW             = 24;
	localparam int          SET_CNT        = 4;
	// Configuration codes that carry the controller (111, 211, 411)
	localparam logic [11:0] CFG_A          = 12'h06f;
	localparam logic [11:0] CFG_B          = 12'h0d3;
	localparam logic [11:0] CFG_C          = 12'h19b;
	// Actual value sources and fixed start function
	localparam logic [7:0]  SRC_ANALOG1    = 8'h01;
	localparam logic [7:0]  SRC_REPFREQ    = 8'h20;
	localparam logic [7:0]  START_FN_CODE  = 8'h0d;
	// Missing actual value threshold, 0.5 %
	localparam logic signed [PW-1:0] MISS_THR = 16'sh0032;
	localparam logic signed [PW-1:0] PCT_FULL = 16'sh2710;
	// Register offsets
	localparam logic [11:0] OFS_CONFIG     = 12'h000;
	localparam logic [11:0] OFS_MODE       = 12'h004;
	localparam logic [11:0] OFS_SOURCE     = 12'h008;
	localparam logic [11:0] OFS_STARTFN    = 12'h00c;
	localparam logic [11:0] OFS_FMIN       = 12'h010;
	localparam logic [11:0] OFS_FMAX       = 12'h014;
	localparam logic [11:0] OFS_DECEL      = 12'h018;
	localparam logic [11:0] OFS_STATUS     = 12'h01c;
	localparam logic [11:0] OFS_FOUT       = 12'h020;
	localparam logic [11:0] OFS_DEV        = 12'h024;
	localparam logic [4:0]  SET_REGION     = 5'h01;
	localparam logic [4:0]  SOFS_FIXF      = 5'h00;
	localparam logic [4:0]  SOFS_MAXP      = 5'h04;
	localparam logic [4:0]  SOFS_HYST      = 5'h08;
	localparam logic [4:0]  SOFS_GAIN      = 5'h0c;
	localparam logic [4:0]  SOFS_TI        = 5'h10;
	// Reset values
	localparam logic [11:0] RST_CONFIG     = 12'h06f;
	localparam logic [7:0]  RST_SOURCE     = 8'h01;
	localparam logic [FW-1:0] RST_FMIN     = 24'h000000;
	localparam logic [FW-1:0] RST_FMAX     = 24'h001388;
	localparam logic [FW-1:0] RST_DECEL    = 24'h000001;
	localparam logic [FW-1:0] RST_FIXF     = 24'h000000;
	localparam logic [FW-1:0] RST_MAXP     = 24'h001388;
	localparam logic [PW-1:0] RST_HYST     = 16'h03e8;
	localparam logic [PW-1:0] RST_GAIN     = 16'h0064;
	localparam logic [15:0]   RST_TI       = 16'h00c8;

	// Operating modes
	typedef enum logic [2:0] {
		MODE_OFF = 3'h0, MODE_STD = 3'h1, MODE_FILL1 = 3'h2,
		MODE_FILL2 = 3'h3, MODE_SPEED = 3'h4, MODE_VOLFLOW = 3'h5
	} ppc_mode_t;

	// Controller phase, Gray along idle, run, fallback
	typedef enum logic [1:0] {
		CTL_IDLE = 2'b00, CTL_RUN = 2'b01, CTL_FALL = 2'b11, CTL_BYPASS = 2'b10
	} ppc_ctl_t;

	// One data set of controller settings
	typedef struct packed {
		logic signed [FW-1:0] fixF;
		logic [FW-1:0]        maxP;
		logic [PW-1:0]        hyst;
		logic signed [PW-1:0] gain;
		logic [15:0]          ti;
	} ppc_set_t;

	// Status flags shown to software and to the drive
	typedef struct packed {
		logic fl2Hold;
		logic fallback;
		logic missing;
		logic active;
		logic absent;
	} ppc_status_t;
endpackage : ppc_pkg

/* sim/ppc_far_side.sv */
// Far side model: process sensor feeding the analog and frequency actual inputs
`timescale 1ns/1ps
module ppc_far_side
	import ppc_pkg::*;
(
	input  wire logic                 sys_clk,  // System clock
	input  wire logic signed [PW-1:0] actVal,   // Measured process value
	input  wire logic                 useFreq,  // Sensor wired to frequency input
	output logic signed [PW-1:0]      anaOut,   // Analog input one level
	output logic signed [PW-1:0]      freqOut   // Repetition frequency level
);
	logic signed [PW-1:0] junk = 16'sh1234;
	// Unwired channel toggles each cycle, so a wrong source pick cannot match by luck
	always_ff @(posedge sys_clk)
		junk <= ~junk;
	assign anaOut  = useFreq ? junk : actVal;
	assign freqOut = useFreq ? actVal : junk;
endmodule : ppc_far_side

/* sim/ppc_process_pi_controller_bench.sv */
// Self-checking bench of the process PI controller
`timescale 1ns/1ps
module ppc_process_pi_controller_bench;
	import ppc_pkg::*;
	localparam int TK = 8;
	logic                 sys_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, runEn = 0, useFreq = 0;
	logic [31:0]          haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h14fa7d47;
	logic [1:0]           htrans = 0, dsSel = 0;
	logic [2:0]           hsize = 3'h2;
	logic                 hreadyout, hresp;
	logic signed [PW-1:0] refPct = 0, actVal = 0, ana, frq;
	logic signed [FW-1:0] freqDemand;
	ppc_status_t          ctlStatus;
	int                   n_fail = 0, checks_done = 0, m, ds, rf, ac, p, lo, i;
	int                   gn[2] = '{100, -200};
	int                   mp[2] = '{1500, 5000};
	logic [31:0]          ra[13] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14, 32'h18, 32'h80, 32'h84,
		32'h88, 32'h8c, 32'h90, 32'h300};
	logic [31:0]          re[13] = '{32'(RST_CONFIG), 32'h0, 32'(RST_SOURCE), 32'(START_FN_CODE),
		32'(RST_FMIN), 32'(RST_FMAX), 32'(RST_DECEL), 32'(RST_FIXF), 32'(RST_MAXP), 32'(RST_HYST),
		32'(RST_GAIN), 32'(RST_TI), 32'h0};

	// Free running 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	ppc_process_pi_controller #(.TICK_CYC(TK), .NSETS(SET_CNT)) u_ppc_process_pi_controller (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .refPct(refPct), .multifunction_analog_input_one(ana),
		.repetition_frequency_input(frq), .run_enable_input(runEn), .dataSetSel(dsSel),
		.freqDemand(freqDemand), .ctlStatus(ctlStatus));
	ppc_far_side u_ppc_far_side (.sys_clk(sys_clk), .actVal(actVal), .useFreq(useFreq), .anaOut(ana),
		.freqOut(frq));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic wrap_up();
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single AHB transfer; waits on hready with a bound, never on a fixed count
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++k < 20);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++k < 40);
		rd = (hresp === 1'b0) ? hrdata : ~hrdata;  // Error response spoils the read
		if (k >= 40)
		begin
			n_fail++;
			wrap_up();
		end
	endtask : bus

	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc

	// Whole control ticks, the loop's own fixed update period
	task automatic ticks(input int n);
		repeat (n * TK) @(posedge sys_clk);
	endtask : ticks

	// Main sequence
	initial
	begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 13; i++)
			rdc(ra[i], re[i]);
		bus(1'b1, 32'hc, 32'h0);
		rdc(32'hc, 32'h0000000d);
		bus(1'b1, 32'h4, 32'h6);
		rdc(32'h4, 32'h0);
		refPct <= 16'sd5000;
		runEn <= 1'b1;
		ticks(3);
		chk(32'(freqDemand), 32'd2500);
		bus(1'b1, 32'h0, 32'h64);
		ticks(2);
		chk(32'(ctlStatus.absent), 32'h1);
		bus(1'b1, 32'h0, 32'hd3);
		ticks(2);
		chk(32'(ctlStatus.absent), 32'h0);
		// Loss of release forces zero demand in a closed loop mode
		bus(1'b1, 32'h4, 32'h1);
		runEn <= 1'b0;
		ticks(2);
		chk(32'(freqDemand), 32'h0);
		chk(32'(ctlStatus.active), 32'h0);
		bus(1'b1, 32'h10, 32'd300);
		bus(1'b1, 32'h18, 32'd100);
		bus(1'b1, 32'h90, 32'h0);
		actVal <= 16'sd20;
		runEn <= 1'b1;
		ticks(8);
		chk(32'(freqDemand), 32'd300);
		chk(32'(ctlStatus.fallback), 32'h1);
		chk(32'(ctlStatus.missing), 32'h1);
		chk(32'(ctlStatus.active), 32'h1);
		actVal <= 16'sd6000;
		ticks(3);
		chk(32'(ctlStatus.fallback), 32'h0);
		// Fill level one: fixed target, then a target below the minimum
		bus(1'b1, 32'h80, 32'd2000);
		bus(1'b1, 32'h4, 32'h2);
		actVal <= 16'sd10;
		ticks(20);
		chk(32'(freqDemand), 32'd2000);
		bus(1'b1, 32'h80, 32'd100);
		ticks(20);
		chk(32'(freqDemand), 32'd300);
		bus(1'b1, 32'h4, 32'h3);
		actVal <= 16'sd6000;
		ticks(4);
		chk(32'(ctlStatus.fl2Hold), 32'h1);
		chk(32'(freqDemand), 32'd300);
		actVal <= 16'sd3000;
		ticks(3);
		chk(32'(ctlStatus.fl2Hold), 32'h0);
		chk(32'(freqDemand), 32'd2000);
		rdc(32'h20, 32'd2000);
		rdc(32'h24, 32'd2000);
		// Random P-only runs over modes, sources and data sets
		bus(1'b1, 32'h84, 32'd1500);
		bus(1'b1, 32'hac, 32'hffffff38);
		bus(1'b1, 32'hb0, 32'h0);
		for (i = 0; i < 24; i++)
		begin
			m = int'(rnd() % 3);
			m = m == 0 ? 1 : (m == 1 ? 4 : 5);
			ds = int'(rnd() & 32'h1);
			rf = int'(rnd() % 10001);
			ac = 50 + int'(rnd() % 9951);
			useFreq <= (rnd() & 32'h1) != 0;
			bus(1'b1, 32'h4, 32'(m));
			bus(1'b1, 32'h8, useFreq ? 32'd32 : 32'd1);
			dsSel <= 2'(ds);
			refPct <= 16'(rf);
			actVal <= 16'(ac);
			ticks(3);
			// Volume flow: whole square root of the actual, kept in 0.01 % units
			if (m == 5)
			begin
				lo = 0;
				while ((lo + 1) * (lo + 1) <= ac)
					lo++;
				ac = lo * 100;
			end
			p = gn[ds] * (rf - ac) / 100;
			p = p > mp[ds] ? mp[ds] : (p < -mp[ds] ? -mp[ds] : p);
			lo = m == 4 ? -5000 : 300;
			p = p > 5000 ? 5000 : (p < lo ? lo : p);
			chk(32'(freqDemand), 32'(p));
		end
		// Integral part saturates at the maximum, then rests inside the hysteresis band
		dsSel <= 2'h0;
		refPct <= 16'sd5000;
		actVal <= 16'sd2000;
		bus(1'b1, 32'h4, 32'h1);
		bus(1'b1, 32'h90, 32'd10);
		ticks(20);
		chk(32'(freqDemand), 32'd5000);
		actVal <= 16'sd5500;
		ticks(5);
		chk(32'(freqDemand), 32'd4500);
		rdc(32'h24, 32'(-500));
		runEn <= 1'b0;
		ticks(1);
		chk(32'(freqDemand), 32'h0);
		// Release again: integral must start from zero, P alone sits under the minimum
		runEn <= 1'b1;
		ticks(3);
		chk(32'(freqDemand), 32'd300);
		wrap_up();
	end
endmodule : ppc_process_pi_controller_bench
